// File: pkg/suc_defines.svh
// register offsets, field positions, reset values and list opcodes of the sync/update bank
`ifndef SUC_DEFINES_SVH
`define SUC_DEFINES_SVH

`define SUC_ADDR_W          12
`define SUC_DATA_W          8
`define SUC_OFS_SYSTEM      12'h230
`define SUC_OFS_UPDATE      12'h232
`define SUC_OFS_SEG_FIRST   12'ha00
`define SUC_OFS_SEG_LAST    12'ha16
`define SUC_SEG_COUNT       23
`define SUC_SEG_IDX_W       5

`define SUC_BIT_NO_RUNT     3
`define SUC_BIT_ALIGN_PD    2
`define SUC_BIT_DREF_PD     1
`define SUC_BIT_SOFT_ALIGN  0
`define SUC_BIT_UPDATE      0
`define SUC_SYSTEM_MASK     8'h0f
`define SUC_SYSTEM_RESET    8'h00

`define SUC_OP_APPLY        8'h80
`define SUC_OP_END          8'hff

`endif

// File: pkg/suc_pkg.sv
// types shared by the sync/update register bank
`default_nettype none
package suc_pkg;

    // meaning of one entry of the eeprom segment list
    typedef enum logic [1:0] {
        SUC_SEG_RANGE,
        SUC_SEG_APPLY,
        SUC_SEG_END
    } suc_seg_kind_t;

    // control levels handed to the clock distribution section
    typedef struct packed {
        logic no_runt;
        logic align_pd;
        logic dref_pd;
        logic align_hold;
    } suc_sys_ctl_t;

    // register write/read request from the serial port engine
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } suc_req_t;

endpackage : suc_pkg
`default_nettype wire

// File: rtl/suc_regs.sv
// system control, update and eeprom segment list registers of the clock generator
// Operation
// - system bit 3 at 1 disables anti-runt circuitry in power-on alignment; default enabled
// - system bit 2 at 1 powers down the output alignment function
// - system bit 1 at 1 powers down the distribution reference
// - soft align bit: 1 holds channels static, 1-to-0 triggers alignment
// - writing 1 to update bit copies buffer registers into active registers
// - update bit clears itself after the transfer
// - 23 segment registers hold start addresses and byte counts for the eeprom
// - segment entries also carry apply and end-of-data opcodes
// - reset list transfers all registers then applies the buffered registers
`include "suc_defines.svh"
`default_nettype none
module suc_regs (
    input  wire logic                      clock,
    input  wire logic                      resetn,
    input  wire suc_pkg::suc_req_t         req,
    output logic [`SUC_DATA_W-1:0]         rdata,
    output suc_pkg::suc_sys_ctl_t          sys_ctl,
    output logic                           align_req,
    output logic                           apply_pulse,
    input  wire logic [`SUC_SEG_IDX_W-1:0] seg_idx,
    output logic [`SUC_DATA_W-1:0]         seg_data,
    output suc_pkg::suc_seg_kind_t         seg_kind
);

    // reset content of the segment list: seven ranges as (count, addr hi, addr lo),
    // then apply, then end; the counts cover every register of the device
    function automatic logic [7:0] seg_default(input int idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            0:  v = 8'h05;
            1:  v = 8'h00;
            2:  v = 8'h00;
            3:  v = 8'h1c;
            4:  v = 8'h00;
            5:  v = 8'h10;
            6:  v = 8'h10;
            7:  v = 8'h00;
            8:  v = 8'hf0;
            9:  v = 8'h04;
            10: v = 8'h01;
            11: v = 8'h40;
            12: v = 8'h0b;
            13: v = 8'h01;
            14: v = 8'h90;
            15: v = 8'h02;
            16: v = 8'h01;
            17: v = 8'he0;
            18: v = 8'h04;
            19: v = 8'h02;
            20: v = 8'h30;
            21: v = `SUC_OP_APPLY;
            22: v = `SUC_OP_END;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : seg_default

    // classify one list byte; used only for the seg_kind output of the eeprom port
    function automatic suc_pkg::suc_seg_kind_t seg_decode(input logic [7:0] b);
        suc_pkg::suc_seg_kind_t k;
        k = suc_pkg::SUC_SEG_RANGE;
        if (b == `SUC_OP_APPLY) begin
            k = suc_pkg::SUC_SEG_APPLY;
        end else if (b == `SUC_OP_END) begin
            k = suc_pkg::SUC_SEG_END;
        end
        return k;
    endfunction : seg_decode

    // address decode of the segment window
    function automatic logic seg_hit(input logic [11:0] a);
        return (a >= `SUC_OFS_SEG_FIRST) && (a <= `SUC_OFS_SEG_LAST);
    endfunction : seg_hit

    logic [7:0] sys_r,      sys_nxt;
    logic       upd_r,      upd_nxt;
    logic       areq_r,     areq_nxt;
    logic [7:0] rdata_r,    rdata_nxt;
    logic [7:0] seg_r   [`SUC_SEG_COUNT];
    logic [7:0] seg_nxt [`SUC_SEG_COUNT];
    logic [7:0] sdat_r,     sdat_nxt;
    logic [11:0] seg_ofs;

    assign seg_ofs = req.addr - `SUC_OFS_SEG_FIRST;

    // system register, update strobe and alignment edge
    always_comb begin
        sys_nxt = sys_r;
        if (req.wr && req.addr == `SUC_OFS_SYSTEM) begin
            sys_nxt = req.wdata & `SUC_SYSTEM_MASK;
        end
        // self-clearing: one cycle high per write of 1, nothing to write back
        upd_nxt = req.wr && req.addr == `SUC_OFS_UPDATE
                  && req.wdata[`SUC_BIT_UPDATE];
        // compare against the stored value so a rewrite of 0 gives no second request
        areq_nxt = sys_r[`SUC_BIT_SOFT_ALIGN] && !sys_nxt[`SUC_BIT_SOFT_ALIGN];
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            sys_r  <= `SUC_SYSTEM_RESET;
            upd_r  <= 1'b0;
            areq_r <= 1'b0;
        end else begin
            sys_r  <= sys_nxt;
            upd_r  <= upd_nxt;
            areq_r <= areq_nxt;
        end
    end

    // segment list storage, one byte per entry
    // flip-flops rather than a ram: the list is short and must leave reset with its defaults
    genvar g;
    generate
        for (g = 0; g < `SUC_SEG_COUNT; g++) begin : g_seg
            always_comb begin
                seg_nxt[g] = seg_r[g];
                if (req.wr && seg_hit(req.addr) && seg_ofs == 12'(g)) begin
                    seg_nxt[g] = req.wdata;
                end
            end
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    seg_r[g] <= seg_default(g);
                end else begin
                    seg_r[g] <= seg_nxt[g];
                end
            end
        end
    endgenerate

    // register read path and eeprom controller port; unmapped and update read as zero
    // read data lags the address by one edge, so the host keeps the address for one cycle
    always_comb begin
        rdata_nxt = 8'h00;
        if (req.addr == `SUC_OFS_SYSTEM) begin
            rdata_nxt = sys_r;
        end else if (seg_hit(req.addr)) begin
            rdata_nxt = seg_r[seg_ofs[4:0]];
        end
        sdat_nxt = 8'h00;
        if (seg_idx < 5'(`SUC_SEG_COUNT)) begin
            sdat_nxt = seg_r[seg_idx];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
            sdat_r  <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
            sdat_r  <= sdat_nxt;
        end
    end

    // outputs
    assign rdata              = rdata_r;
    assign seg_data           = sdat_r;
    assign seg_kind           = seg_decode(sdat_r);
    assign sys_ctl.no_runt    = sys_r[`SUC_BIT_NO_RUNT];
    assign sys_ctl.align_pd   = sys_r[`SUC_BIT_ALIGN_PD];
    assign sys_ctl.dref_pd    = sys_r[`SUC_BIT_DREF_PD];
    assign sys_ctl.align_hold = sys_r[`SUC_BIT_SOFT_ALIGN];
    assign align_req          = areq_r;
    assign apply_pulse        = upd_r;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_no_runt_write: assert property (
        req.wr && req.addr == `SUC_OFS_SYSTEM |=> sys_ctl.no_runt == $past(req.wdata[3]))
        else $error("anti-runt disable does not follow system write");
    a_align_pd_write: assert property (
        req.wr && req.addr == `SUC_OFS_SYSTEM |=> sys_ctl.align_pd == $past(req.wdata[2]))
        else $error("alignment power-down does not follow system write");
    a_dref_pd_hold: assert property (
        !(req.wr && req.addr == `SUC_OFS_SYSTEM) |=> $stable(sys_ctl.dref_pd))
        else $error("reference power-down changed without a write");
    a_align_fall_req: assert property (
        $fell(sys_ctl.align_hold) |-> align_req)
        else $error("falling soft align gave no request");
    a_align_req_single: assert property (
        align_req |=> !align_req)
        else $error("alignment request longer than one cycle");
    // back-to-back update writes keep apply high, so the single pulse needs a quiet cycle
    a_update_pulse: assert property (
        req.wr && req.addr == `SUC_OFS_UPDATE && req.wdata[0]
        ##1 !(req.wr && req.addr == `SUC_OFS_UPDATE) |-> apply_pulse ##1 !apply_pulse)
        else $error("update write did not give one apply pulse");
    a_update_idle: assert property (
        !(req.wr && req.addr == `SUC_OFS_UPDATE && req.wdata[0]) |=> !apply_pulse)
        else $error("apply pulse without an update write of 1");
    a_update_cause: assert property (
        apply_pulse |-> $past(req.wr && req.addr == `SUC_OFS_UPDATE))
        else $error("apply pulse without an update write");
    a_seg_kind_end: assert property (
        seg_idx < 5'(`SUC_SEG_COUNT) && seg_r[seg_idx] == `SUC_OP_END
        |=> seg_kind == suc_pkg::SUC_SEG_END)
        else $error("end opcode not recognised");
    a_seg_idx_range: assert property (
        seg_idx >= 5'(`SUC_SEG_COUNT) |=> seg_data == 8'h00)
        else $error("list index past the end did not read zero");
    a_dref_pd_write: assert property (
        req.wr && req.addr == `SUC_OFS_SYSTEM |=> sys_ctl.dref_pd == $past(req.wdata[1]))
        else $error("reference power-down does not follow system write");
    a_hold_write: assert property (
        req.wr && req.addr == `SUC_OFS_SYSTEM |=> sys_ctl.align_hold == $past(req.wdata[0]))
        else $error("soft align hold does not follow system write");
    a_align_req_cause: assert property (
        align_req |-> $fell(sys_ctl.align_hold))
        else $error("alignment request without a falling soft align");
    a_sys_read: assert property (
        req.addr == `SUC_OFS_SYSTEM |=> rdata == {4'h0, $past(sys_ctl)})
        else $error("system register read data wrong");
    a_seg_readback: assert property (
        req.wr && req.addr == `SUC_OFS_SEG_FIRST ##1 req.addr == `SUC_OFS_SEG_FIRST
        && !req.wr |=> rdata == $past(req.wdata, 2))
        else $error("segment entry did not read back");

endmodule : suc_regs
`default_nettype wire

// File: verif/suc_host.sv
// host model that issues register writes and reads to the sync/update bank
`default_nettype none
module suc_host (
    input  wire logic           clock,
    output var suc_pkg::suc_req_t req,
    input  wire logic [7:0]     rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    time t_drop = 0;
    initial req = '0;
    // one write, raised on a falling edge and dropped on the next one;
    // a write right behind another waits a cycle so wr never flips twice in one step
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        if (t_drop == $time) begin
            @(negedge clock);
        end
        req = '{wr: 1'b1, addr: a, wdata: d};
        @(negedge clock);
        req.wr = 1'b0;
        req.wdata = ~d; // released data must not keep its last value
        t_drop = $time;
    endtask : wr
    // read: rdata is registered, so it is taken one cycle after the address
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        req.addr = a;
        @(negedge clock);
        d = rdata;
    endtask : rd
endmodule : suc_host
`default_nettype wire

// File: verif/tb.sv
// self-checking bench of the sync/update register bank
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clock = 1'b0;
    logic                   resetn = 1'b0;
    suc_pkg::suc_req_t      req;
    suc_pkg::suc_sys_ctl_t  sys_ctl;
    suc_pkg::suc_seg_kind_t seg_kind, k;
    logic [7:0]             rdata, seg_data, d, b, e;
    logic                   align_req, apply_pulse;
    logic [4:0]             seg_idx = 5'h00;
    int                     err_count = 0, n_checks = 0, cyc = 0;
    // default list: (count, addr hi, addr lo) triples, then apply and end
    logic [7:0] lst [0:22] = '{8'h05, 8'h00, 8'h00, 8'h1c, 8'h00, 8'h10, 8'h10, 8'h00,
        8'hf0, 8'h04, 8'h01, 8'h40, 8'h0b, 8'h01, 8'h90, 8'h02, 8'h01, 8'he0, 8'h04,
        8'h02, 8'h30, 8'h80, 8'hff};

    suc_regs u_suc_regs (.clock(clock), .resetn(resetn), .req(req), .rdata(rdata),
        .sys_ctl(sys_ctl), .align_req(align_req), .apply_pulse(apply_pulse),
        .seg_idx(seg_idx), .seg_data(seg_data), .seg_kind(seg_kind));
    suc_host u_suc_host (.clock(clock), .req(req), .rdata(rdata));

    always #12.5 clock = ~clock;

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
        n_checks++;
        if (g !== ex) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    // hang guard, far above the fewer than a hundred cycles the tests need
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        u_suc_host.rd(12'h230, d);
        chk("system", 8'h00, d);
        chk("ctl", 8'h00, {4'h0, sys_ctl});
        // control bits 1 to 3 alone, upper bits written high must read back 0
        for (int i = 1; i < 4; i++) begin
            b = 8'h01 << i;
            u_suc_host.wr(12'h230, b | 8'hf0);
            chk("ctl", b, {4'h0, sys_ctl});
            u_suc_host.rd(12'h230, d);
            chk("system", b, d);
        end
        $display("test system bits done");
        // hold, rewrite of 1 gives no request, 1-to-0 gives one pulse
        u_suc_host.wr(12'h230, 8'h01);
        chk("hold_req", 8'h01, {3'h0, align_req, sys_ctl});
        u_suc_host.wr(12'h230, 8'h01);
        chk("hold_req", 8'h01, {3'h0, align_req, sys_ctl});
        u_suc_host.wr(12'h230, 8'h00);
        chk("hold_req", 8'h10, {3'h0, align_req, sys_ctl});
        @(negedge clock);
        chk("hold_req", 8'h00, {3'h0, align_req, sys_ctl});
        $display("test soft align done");
        u_suc_host.wr(12'h232, 8'hfe);
        chk("apply", 8'h00, {7'h0, apply_pulse});
        u_suc_host.wr(12'h232, 8'h01);
        chk("apply", 8'h01, {7'h0, apply_pulse});
        u_suc_host.rd(12'h232, d);
        chk("apply", 8'h00, {7'h0, apply_pulse});
        chk("update", 8'h00, d);
        $display("test update done");
        // whole default list on both ports; index 23 and 0xa17 are unmapped
        for (int i = 0; i < 24; i++) begin
            seg_idx = 5'(i);
            u_suc_host.rd(12'ha00 + 12'(i), d);
            e = (i < 23) ? lst[i] : 8'h00;
            k = (e == 8'h80) ? suc_pkg::SUC_SEG_APPLY :
                (e == 8'hff) ? suc_pkg::SUC_SEG_END : suc_pkg::SUC_SEG_RANGE;
            chk("seg", e, seg_data);
            chk("list", e, d);
            chk("kind", {6'h0, k}, {6'h0, seg_kind});
        end
        seg_idx = 5'd22;
        u_suc_host.wr(12'ha16, 8'h80);
        u_suc_host.rd(12'ha16, d);
        chk("list", 8'h80, d);
        chk("kind", {6'h0, suc_pkg::SUC_SEG_APPLY}, {6'h0, seg_kind});
        u_suc_host.wr(12'ha00, 8'h3c);
        u_suc_host.rd(12'ha00, d);
        chk("list", 8'h3c, d);
        $display("test segment list done");
        // reset in mid-run must bring back the default list and clear the system bits
        u_suc_host.wr(12'h230, 8'h0e);
        resetn = 1'b0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        u_suc_host.rd(12'ha00, d);
        chk("list", 8'h05, d);
        u_suc_host.rd(12'ha16, d);
        chk("list", 8'hff, d);
        chk("kind", {6'h0, suc_pkg::SUC_SEG_END}, {6'h0, seg_kind});
        u_suc_host.rd(12'h230, d);
        chk("system", 8'h00, d);
        chk("ctl", 8'h00, {4'h0, sys_ctl});
        $display("test mid-run reset done");
        conclude();
    end
endmodule : tb
`default_nettype wire
